//--- cpfe_top.sv
// cam position front end: source select, counter, offset, gear and speed scaling
// Notes on behaviour
// - timer source makes count pulses every timebase, 1 to 65535 ms.
// - timer source gives no speed value and no delay compensation.
// - timer counting obeys the same gate and clear as incremental counting.
// - incremental counter wraps to zero at the range limit unless cleared.
// - counting range programmable 2 to 16777216, default 16384.
// - source codes: 2 incremental, 3 gray serial, 5 timer, 6 multi-revolution.
// - reversal setting, default off, inverts encoder counting direction.
// - absolute sources subtract zero offset, default 0, before further processing.
// - incremental sources get no offset correction.
// - compensation mode codes: 1 block, 2 bit, 3 block with split delays.
// - block mode: one delay serves each group of eight outputs.
// - compensation lead grows with speed, moving switching points earlier.
// - speed scaled by factor 0 to 9999, default 60.
// - position rescaled to fictitious resolution, rounded up above one half.
// - fictitious resolution 2..32500 absolute, up to counting range times 32500 incremental.
// - supported absolute resolutions checked; unsupported flagged in status.
// - language code 0 to 9, default 0.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cpfe_top #(
  parameter int CYC_PER_MS = cpfe_pkg::CPFE_CYC_PER_MS,
  parameter int NBLK       = 2
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite slave
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // encoder side
  input  wire logic                   inc_step,
  input  wire logic                   inc_dir,
  input  wire logic                   count_gate,
  input  wire logic                   count_clear,
  input  wire logic [23:0]            abs_word,
  // to cam evaluation
  output logic [31:0]                 pos_out,
  output logic [31:0]                 speed_out,
  output logic [1:0]                  actuator_delay_comp,
  output logic [NBLK*32-1:0]          lead_on,
  output logic [NBLK*32-1:0]          lead_off
);
  import cpfe_pkg::*;

  logic [2:0]  src_q;
  logic        rev_q;
  logic [1:0]  itc_q;
  logic [3:0]  lang_q;
  logic [24:0] range_q, res_q, zofs_q;
  logic [24:0] corr_q;
  cpfe_div_t   dstate_q;
  logic [31:0] fict_q;
  logic [15:0] tbase_q;
  logic [13:0] sfact_q;
  logic [9:0]  dly_on_q, dly_off_q;
  logic        is_abs, is_timer, res_bad;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    return o;
  endfunction

  function automatic logic [23:0] gray2bin(input logic [23:0] g);
    logic [23:0] b;
    b[23] = g[23];
    for (int i = 22; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  assign is_abs   = (src_q == CPFE_SRC_GRAY) || (src_q == CPFE_SRC_MREV);
  assign is_timer = (src_q == CPFE_SRC_TIMER);

  // supported absolute resolutions; anything else is flagged, not blocked
  always_comb begin
    res_bad = 1'b0;
    if (src_q == CPFE_SRC_GRAY) begin
      res_bad = !(res_q == 25'd360 || res_q == 25'd720 || res_q == 25'd1000 ||
                  res_q == 25'd3600 || res_q == 25'd7200 ||
                  (res_q >= 25'd2 && res_q <= 25'd16384 && (res_q & (res_q - 25'd1)) == '0));
    end else if (src_q == CPFE_SRC_MREV) begin
      res_bad = (res_q != CPFE_RANGE_MAX);
    end
  end

  // ---------------- axi4-lite slave ----------------
  logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q, rdata_q, wm, wcur, rd_mux;
  logic [3:0]  w_strb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        do_wr, wr_hit, rd_hit;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_wr         = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit        = aw_addr_q <= CPFE_OFS_DLY && aw_addr_q[1:0] == 2'b00;

  // address and data are caught independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // present value of the addressed setting, merged with the strobed bytes
  always_comb begin
    unique case (aw_addr_q)
      CPFE_OFS_CTRL:  wcur = {16'h0000, lang_q, 2'b00, itc_q, 3'b000, rev_q, 1'b0, src_q};
      CPFE_OFS_RANGE: wcur = {7'h00, range_q};
      CPFE_OFS_ZOFS:  wcur = {7'h00, zofs_q};
      CPFE_OFS_RES:   wcur = {7'h00, res_q};
      CPFE_OFS_FICT:  wcur = fict_q;
      CPFE_OFS_TBASE: wcur = {16'h0000, tbase_q};
      CPFE_OFS_SFACT: wcur = {18'h00000, sfact_q};
      CPFE_OFS_DLY:   wcur = {6'h00, dly_off_q, 6'h00, dly_on_q};
      default:        wcur = 32'h00000000;
    endcase
    wm = merge(wcur, w_data_q, w_strb_q);
  end

  // configuration writes; out-of-range values are dropped, old value kept; zero offset is taken unchecked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q     <= CPFE_SRC_INC;
      rev_q     <= 1'b0;
      itc_q     <= CPFE_ITC_BLOCK;
      lang_q    <= 4'h0;
      range_q   <= CPFE_RANGE_RST;
      zofs_q    <= 25'h0000000;
      res_q     <= CPFE_RES_RST;
      fict_q    <= CPFE_FICT_RST;
      tbase_q   <= CPFE_TBASE_RST;
      sfact_q   <= CPFE_SFACT_RST;
      dly_on_q  <= 10'h000;
      dly_off_q <= 10'h000;
    end else if (do_wr) begin
      unique case (aw_addr_q)
        CPFE_OFS_CTRL: begin
          if (wm[2:0] == CPFE_SRC_INC || wm[2:0] == CPFE_SRC_GRAY ||
              wm[2:0] == CPFE_SRC_TIMER || wm[2:0] == CPFE_SRC_MREV)
            src_q <= wm[CPFE_CTRL_SRC_LSB +: 3];
          rev_q <= wm[CPFE_CTRL_REV_BIT];
          if (wm[CPFE_CTRL_ITC_LSB +: 2] != 2'b00) itc_q <= wm[CPFE_CTRL_ITC_LSB +: 2];
          if (wm[CPFE_CTRL_LANG_LSB +: 4] <= CPFE_LANG_MAX)
            lang_q <= wm[CPFE_CTRL_LANG_LSB +: 4];
        end
        CPFE_OFS_RANGE: begin
          if (wm >= 32'(CPFE_RANGE_MIN) && wm <= 32'(CPFE_RANGE_MAX)) range_q <= wm[24:0];
        end
        CPFE_OFS_ZOFS: begin
          zofs_q <= wm[24:0];
        end
        CPFE_OFS_RES: begin
          if (wm >= 32'(CPFE_RANGE_MIN) && wm <= 32'(CPFE_RANGE_MAX)) res_q <= wm[24:0];
        end
        CPFE_OFS_FICT: begin
          if (wm >= 32'd2 && (is_abs ? wm <= CPFE_FICT_MAXA
                              : 40'(wm) <= 40'(range_q) * 40'(CPFE_FICT_MAXA)))
            fict_q <= wm;
        end
        CPFE_OFS_TBASE: begin
          if (wm[31:16] == 16'h0000 && wm[15:0] != 16'h0000) tbase_q <= wm[15:0];
        end
        CPFE_OFS_SFACT: begin
          if (wm <= 32'(CPFE_SFACT_MAX)) sfact_q <= wm[13:0];
        end
        CPFE_OFS_DLY: begin
          if (wm[9:0] <= CPFE_DLY_MAX) dly_on_q <= wm[9:0];
          if (wm[25:16] <= CPFE_DLY_MAX) dly_off_q <= wm[25:16];
        end
        default: ;
      endcase
    end
  end

  // read path, one cycle after the address is taken
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      CPFE_OFS_CTRL:  rd_mux = {16'h0000, lang_q, 2'b00, itc_q, 3'b000, rev_q, 1'b0, src_q};
      CPFE_OFS_RANGE: rd_mux = {7'h00, range_q};
      CPFE_OFS_ZOFS:  rd_mux = {7'h00, zofs_q};
      CPFE_OFS_RES:   rd_mux = {7'h00, res_q};
      CPFE_OFS_FICT:  rd_mux = fict_q;
      CPFE_OFS_TBASE: rd_mux = {16'h0000, tbase_q};
      CPFE_OFS_SFACT: rd_mux = {18'h00000, sfact_q};
      CPFE_OFS_DLY:   rd_mux = {6'h00, dly_off_q, 6'h00, dly_on_q};
      CPFE_OFS_POS:   rd_mux = pos_out;
      CPFE_OFS_SPEED: rd_mux = speed_out;
      CPFE_OFS_RAW:   rd_mux = {7'h00, corr_q};
      CPFE_OFS_STAT:  rd_mux = {31'h00000000, res_bad};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? 2'b00 : 2'b10;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- timebase ----------------
  logic [31:0] ms_cnt_q;
  logic [15:0] tb_cnt_q;
  logic        ms_tick, tb_pulse;

  assign ms_tick  = (ms_cnt_q == 32'(CYC_PER_MS - 1));
  assign tb_pulse = is_timer && ms_tick && (tb_cnt_q + 16'h0001 >= tbase_q);

  // millisecond divider and timebase interval counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_q <= 32'h00000000;
      tb_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h00000000 : ms_cnt_q + 32'h00000001;
      if (!is_timer || tb_pulse) tb_cnt_q <= 16'h0000;
      else if (ms_tick) tb_cnt_q <= tb_cnt_q + 16'h0001;
    end
  end

  // ---------------- counter and absolute path ----------------
  logic [24:0] cnt_q, abs_bin, abs_rev, pos_sel;
  logic        adv, up;

  // timer pulses behave as internal up-counts through the same gate
  assign adv = count_gate && (is_timer ? tb_pulse : (src_q == CPFE_SRC_INC) && inc_step);
  assign up  = is_timer || (inc_dir ^ rev_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 25'h0000000;
    end else if (count_clear) begin
      cnt_q <= 25'h0000000;
    end else if (adv) begin
      if (up) cnt_q <= (cnt_q >= range_q - 25'd1) ? 25'h0000000 : cnt_q + 25'd1;
      else cnt_q <= (cnt_q == 25'h0000000) ? range_q - 25'd1 : cnt_q - 25'd1;
    end
  end

  // absolute word: gray decode, reversal, then offset modulo resolution
  assign abs_bin = {1'b0, (src_q == CPFE_SRC_GRAY) ? gray2bin(abs_word) : abs_word};
  assign abs_rev = (rev_q && abs_bin != '0) ? res_q - abs_bin : abs_bin;
  assign pos_sel = !is_abs ? cnt_q :
                   (abs_rev >= zofs_q) ? abs_rev - zofs_q : abs_rev + res_q - zofs_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) corr_q <= 25'h0000000;
    else corr_q <= pos_sel;
  end

  // ---------------- speed measurement ----------------
  logic [24:0] prev_q, fwd, dlt;
  logic [31:0] acc_q, win_cnt_q, ms_acc_q, per_ms_q;
  logic [9:0]  win_ms_q;
  logic        spd_req_q;
  logic [24:0] den;

  assign den = is_abs ? res_q : range_q;
  // shortest way round between two samples, so wraps do not look fast
  assign fwd = (corr_q >= prev_q) ? corr_q - prev_q : corr_q + den - prev_q;
  assign dlt = (fwd > den - fwd) ? den - fwd : fwd;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q    <= 25'h0000000;
      acc_q     <= 32'h00000000;
      win_cnt_q <= 32'h00000000;
      ms_acc_q  <= 32'h00000000;
      per_ms_q  <= 32'h00000000;
      win_ms_q  <= 10'h000;
      spd_req_q <= 1'b0;
    end else begin
      prev_q <= corr_q;
      if (ms_tick) begin
        per_ms_q <= ms_acc_q + 32'(dlt);
        ms_acc_q <= 32'h00000000;
      end else begin
        ms_acc_q <= ms_acc_q + 32'(dlt);
      end
      if (ms_tick && win_ms_q == CPFE_SPD_WIN_MS - 10'd1) begin
        win_cnt_q <= acc_q + 32'(dlt);
        acc_q     <= 32'h00000000;
        win_ms_q  <= 10'h000;
        spd_req_q <= 1'b1;
      end else begin
        acc_q <= acc_q + 32'(dlt);
        if (ms_tick) win_ms_q <= win_ms_q + 10'd1;
        if (dstate_q == CPFE_D_SPD) spd_req_q <= 1'b0;
      end
    end
  end

  // ---------------- shared serial divider ----------------
  logic [63:0] num_q;
  logic [40:0] rem_q, rem_n;
  logic [39:0] dden_q;
  logic [6:0]  bit_q;

  assign rem_n = {rem_q[39:0], num_q[63]};

  // position and speed share one divider; speed goes when its window closes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dstate_q  <= CPFE_D_IDLE;
      num_q     <= 64'h0000000000000000;
      rem_q     <= 41'h00000000000;
      dden_q    <= 40'h0000000000;
      bit_q     <= 7'h00;
      pos_out   <= 32'h00000000;
      speed_out <= 32'h00000000;
    end else begin
      unique case (dstate_q)
        CPFE_D_IDLE: begin
          rem_q <= 41'h00000000000;
          bit_q <= 7'h00;
          if (spd_req_q && !is_timer) begin
            dstate_q <= CPFE_D_SPD;
            num_q    <= 64'(win_cnt_q) * 64'(sfact_q);
            dden_q   <= 40'(den);
          end else begin
            dstate_q <= CPFE_D_POS;
            num_q    <= 64'(2) * 64'(corr_q) * 64'(fict_q) + 64'(den) - 64'd1;
            dden_q   <= {14'h0000, den, 1'b0};
          end
        end
        CPFE_D_POS, CPFE_D_SPD: begin
          if (rem_n >= {1'b0, dden_q}) begin
            rem_q <= rem_n - {1'b0, dden_q};
            num_q <= {num_q[62:0], 1'b1};
          end else begin
            rem_q <= rem_n;
            num_q <= {num_q[62:0], 1'b0};
          end
          bit_q <= bit_q + 7'd1;
          if (bit_q == 7'd63) begin
            dstate_q <= CPFE_D_IDLE;
            if (dstate_q == CPFE_D_POS) pos_out <= {num_q[30:0], rem_n >= {1'b0, dden_q}};
            else speed_out <= {num_q[30:0], rem_n >= {1'b0, dden_q}};
          end
        end
      endcase
      if (is_timer) speed_out <= 32'h00000000;
    end
  end

  // ---------------- actuator delay compensation ----------------
  assign actuator_delay_comp = itc_q;

  // one lead per block of eight outputs: counts per ms times delay in ms
  genvar b;
  for (b = 0; b < NBLK; b++) begin : g_blk
    always_ff @(posedge aclk) begin
      if (!aresetn || is_timer) begin
        lead_on[b*32 +: 32]  <= 32'h00000000;
        lead_off[b*32 +: 32] <= 32'h00000000;
      end else begin
        lead_on[b*32 +: 32]  <= 32'(per_ms_q * 32'(dly_on_q));
        lead_off[b*32 +: 32] <= 32'(per_ms_q *
                                    32'(itc_q == CPFE_ITC_SPLIT ? dly_off_q : dly_on_q));
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TB_TICK: assert property (tb_pulse |-> ms_tick && is_timer)
    else $error("timebase pulse off the millisecond tick");
  AST_TB_LIMIT: assert property (tbase_q != 16'h0000)
    else $error("timebase zero");
  AST_NO_SPEED: assert property (is_timer && $past(is_timer) |-> speed_out == 32'h0)
    else $error("speed shown in timer mode");
  AST_NO_LEAD: assert property (is_timer |=> lead_on == '0 || !is_timer)
    else $error("lead present in timer mode");
  AST_GATE: assert property (!count_gate && !count_clear |=> $stable(cnt_q))
    else $error("counter moved with gate closed");
  AST_WRAP: assert property (adv && up && !count_clear && cnt_q == range_q - 25'd1
                             |=> cnt_q == 25'h0)
    else $error("counter missed wrap to zero");
  AST_RANGE: assert property (range_q >= CPFE_RANGE_MIN && range_q <= CPFE_RANGE_MAX)
    else $error("counting range out of limits");
  AST_INC_NOOFS: assert property (!is_abs |=> corr_q == $past(cnt_q))
    else $error("offset applied to incremental count");
  AST_SFACT: assert property (sfact_q <= CPFE_SFACT_MAX)
    else $error("speed factor above limit");
  AST_LANG: assert property (lang_q <= CPFE_LANG_MAX)
    else $error("language code above limit");
endmodule

//--- cpfe_pkg.sv
// shared constants and types of the cam position front end
package cpfe_pkg;
  // register byte offsets
  localparam logic [7:0] CPFE_OFS_CTRL  = 8'h00;
  localparam logic [7:0] CPFE_OFS_RANGE = 8'h04;
  localparam logic [7:0] CPFE_OFS_ZOFS  = 8'h08;
  localparam logic [7:0] CPFE_OFS_RES   = 8'h0C;
  localparam logic [7:0] CPFE_OFS_FICT  = 8'h10;
  localparam logic [7:0] CPFE_OFS_TBASE = 8'h14;
  localparam logic [7:0] CPFE_OFS_SFACT = 8'h18;
  localparam logic [7:0] CPFE_OFS_DLY   = 8'h1C;
  localparam logic [7:0] CPFE_OFS_POS   = 8'h20;
  localparam logic [7:0] CPFE_OFS_SPEED = 8'h24;
  localparam logic [7:0] CPFE_OFS_RAW   = 8'h28;
  localparam logic [7:0] CPFE_OFS_STAT  = 8'h2C;
  // control field positions
  localparam int CPFE_CTRL_SRC_LSB  = 0;
  localparam int CPFE_CTRL_REV_BIT  = 4;
  localparam int CPFE_CTRL_ITC_LSB  = 8;
  localparam int CPFE_CTRL_LANG_LSB = 12;
  // source type codes
  localparam logic [2:0] CPFE_SRC_INC   = 3'h2;
  localparam logic [2:0] CPFE_SRC_GRAY  = 3'h3;
  localparam logic [2:0] CPFE_SRC_TIMER = 3'h5;
  localparam logic [2:0] CPFE_SRC_MREV  = 3'h6;
  // actuator_delay_comp mode codes
  localparam logic [1:0] CPFE_ITC_BLOCK = 2'h1;
  localparam logic [1:0] CPFE_ITC_BIT   = 2'h2;
  localparam logic [1:0] CPFE_ITC_SPLIT = 2'h3;
  // reset values and limits
  localparam logic [24:0] CPFE_RANGE_RST = 25'h0004000;
  localparam logic [24:0] CPFE_RANGE_MIN = 25'h0000002;
  localparam logic [24:0] CPFE_RANGE_MAX = 25'h1000000;
  localparam logic [24:0] CPFE_RES_RST   = 25'h0004000;
  localparam logic [31:0] CPFE_FICT_RST  = 32'h00004000;
  localparam logic [31:0] CPFE_FICT_MAXA = 32'h00007EF4;
  localparam logic [15:0] CPFE_TBASE_RST = 16'h03E8;
  localparam logic [13:0] CPFE_SFACT_RST = 14'h003C;
  localparam logic [13:0] CPFE_SFACT_MAX = 14'h270F;
  localparam logic [3:0]  CPFE_LANG_MAX  = 4'h9;
  localparam logic [9:0]  CPFE_DLY_MAX   = 10'h3E7;
  // timing: one millisecond tick at 200 MHz, one second speed window
  localparam int CPFE_CLK_NS     = 5;
  localparam int CPFE_MS_NS      = 1000000;
  localparam int CPFE_CYC_PER_MS = CPFE_MS_NS / CPFE_CLK_NS;
  localparam logic [9:0] CPFE_SPD_WIN_MS = 10'h3E8;
  // divider sequencer states
  typedef enum logic [2:0] {
    CPFE_D_IDLE = 3'b001,
    CPFE_D_POS  = 3'b010,
    CPFE_D_SPD  = 3'b100
  } cpfe_div_t;
endpackage

//--- cpfe_enc_model.sv
// rotary encoder model: step pulses and absolute word
`timescale 1ns/1ps
module cpfe_enc_model (
  // clock
  input  wire logic aclk,
  // encoder outputs
  output logic        inc_step,
  output logic        inc_dir,
  output logic [23:0] abs_word
);
  // shaft at rest until a task moves it
  initial begin
    inc_step = 1'b0;
    inc_dir  = 1'b1;
    abs_word = 24'h000000;
  end
  // n steps, one every gap cycles; a large gap makes a slow shaft
  task automatic move(input int n, input logic up, input int gap);
    for (int k = 0; k < n; k++) begin
      @(posedge aclk);
      inc_step <= 1'b1;
      inc_dir  <= up;
      @(posedge aclk);
      inc_step <= 1'b0;
      repeat (gap - 2) @(posedge aclk);
    end
  endtask
  // absolute word stays below the resolution; gray for the serial type
  task automatic put(input logic [23:0] p, input logic g);
    @(posedge aclk);
    abs_word <= g ? p ^ (p >> 1) : p;
  endtask
endmodule

//--- cam_position_front_end_bench.sv
// self-checking bench of the cam position front end
`timescale 1ns/1ps
module cam_position_front_end_bench;
  import cpfe_pkg::*;
  // bench signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, count_gate, count_clear, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, inc_step, inc_dir;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, pos_out, speed_out, rdat, r0;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, actuator_delay_comp;
  logic [23:0] abs_word;
  logic [63:0] lead_on, lead_off;
  int          n_fail, compares;
  // reset words of the eight settings, one word apart
  logic [31:0] rst_v [8] = '{32'h102, 32'h4000, 32'h0, 32'h4000, 32'h4000, 32'h3E8,
                             32'h3C, 32'h0};
  // a 20-cycle millisecond keeps the one-second speed window short
  cpfe_top #(.CYC_PER_MS(20), .NBLK(2)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .inc_step, .inc_dir, .count_gate,
    .count_clear, .abs_word, .pos_out, .speed_out, .actuator_delay_comp, .lead_on,
    .lead_off
  );
  cpfe_enc_model enc (.aclk, .inc_step, .inc_dir, .abs_word);
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic to(input int i);
    if (i >= 50) begin
      n_fail++;
      $display("[FAIL] %0t bus wait ran out", $time);
      end_sim();
    end
  endtask
  // readies are sampled at the falling edge, where they have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   i;
    logic ta, tw, ao, wo;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !(ta && tw); i++) begin
      @(negedge aclk);
      ao = s_axi_awready;
      wo = s_axi_wready;
      @(posedge aclk);
      ta = ta | ao;
      tw = tw | wo;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end
    to(i);
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++)
      @(negedge aclk);
    to(i);
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int   i;
    logic ok;
    ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !ok; i++) begin
      @(negedge aclk);
      ok = s_axi_arready;
      @(posedge aclk);
    end
    to(i);
    s_axi_arvalid <= 1'b0;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++)
      @(negedge aclk);
    to(i);
    rdat = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // wait for position (s=0) or speed (s=1) to reach e within n cycles
  task automatic wq(input logic s, input logic [31:0] e, input int n);
    int k;
    @(negedge aclk);
    for (k = 0; k < n && (s ? speed_out : pos_out) !== e; k++)
      @(negedge aclk);
    chk(s ? speed_out : pos_out, e);
    if (k == n) end_sim();
  endtask
  task automatic clr();
    @(posedge aclk) count_clear <= 1'b1;
    @(posedge aclk) count_clear <= 1'b0;
  endtask
  task automatic t_reset();
    chk(32'(actuator_delay_comp), 32'h1);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), 2'h0);
      chk(rdat, rst_v[i]);
    end
  endtask
  task automatic t_bus();
    logic [2:0] src [5] = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h4};
    rd(8'h30, 2'h2);
    wr(CPFE_OFS_POS, 32'h1, 2'h2);
    for (int i = 0; i < 5; i++) begin
      wr(CPFE_OFS_CTRL, 32'h100 | 32'(src[i]), 2'h0);
      rd(CPFE_OFS_CTRL, 2'h0);
      chk(rdat, (i == 4) ? 32'h106 : 32'h100 | 32'(src[i]));
    end
    for (int m = 1; m < 4; m++) begin
      wr(CPFE_OFS_CTRL, 32'h9002 | 32'(m << 8), 2'h0);
      chk(32'(actuator_delay_comp), 32'(m));
    end
    wr(CPFE_OFS_CTRL, 32'hA002, 2'h0);
    rd(CPFE_OFS_CTRL, 2'h0);
    chk(rdat, 32'h9302);
  endtask
  task automatic t_inc();
    wr(CPFE_OFS_CTRL, 32'h102, 2'h0);
    wr(CPFE_OFS_RANGE, 32'h4, 2'h0);
    wr(CPFE_OFS_RANGE, 32'h1, 2'h0);
    wr(CPFE_OFS_FICT, 32'h5, 2'h0);
    wr(CPFE_OFS_ZOFS, 32'h3, 2'h0);
    @(posedge aclk) count_gate <= 1'b1;
    clr();
    enc.move(5, 1'b1, 2);
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h1);
    wr(CPFE_OFS_CTRL, 32'h112, 2'h0);
    enc.move(1, 1'b1, 2);
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h0);
    wr(CPFE_OFS_CTRL, 32'h102, 2'h0);
    enc.move(3, 1'b1, 2);
    wq(1'b0, 32'h4, 300);
    @(posedge aclk) count_gate <= 1'b0;
    enc.move(2, 1'b1, 2);
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h3);
    clr();
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h0);
  endtask
  task automatic t_abs();
    wr(CPFE_OFS_CTRL, 32'h103, 2'h0);
    wr(CPFE_OFS_RES, 32'h3E8, 2'h0);
    wr(CPFE_OFS_FICT, 32'h3, 2'h0);
    wr(CPFE_OFS_FICT, 32'h7EF5, 2'h0);
    wr(CPFE_OFS_ZOFS, 32'h0, 2'h0);
    enc.put(24'h1F4, 1'b1);
    wq(1'b0, 32'h1, 300);
    enc.put(24'h258, 1'b1);
    wq(1'b0, 32'h2, 300);
    enc.put(24'h64, 1'b1);
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h64);
    wr(CPFE_OFS_ZOFS, rdat, 2'h0);
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h0);
    wr(CPFE_OFS_ZOFS, 32'hA, 2'h0);
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h5A);
    wr(CPFE_OFS_ZOFS, 32'h3DE, 2'h0);
    rd(CPFE_OFS_RAW, 2'h0);
    chk(rdat, 32'h6E);
    rd(CPFE_OFS_STAT, 2'h0);
    chk(rdat, 32'h0);
    wr(CPFE_OFS_RES, 32'h3E9, 2'h0);
    rd(CPFE_OFS_STAT, 2'h0);
    chk(rdat, 32'h1);
  endtask
  // read-to-read spacing is exactly 400 cycles, ten 2 ms intervals
  task automatic t_timer();
    wr(CPFE_OFS_CTRL, 32'h105, 2'h0);
    wr(CPFE_OFS_RANGE, 32'h3E8, 2'h0);
    wr(CPFE_OFS_TBASE, 32'h0, 2'h0);
    wr(CPFE_OFS_TBASE, 32'h2, 2'h0);
    @(posedge aclk) count_gate <= 1'b1;
    clr();
    for (int g = 1; g >= 0; g--) begin
      rd(CPFE_OFS_RAW, 2'h0);
      r0 = rdat;
      repeat (397) @(posedge aclk);
      rd(CPFE_OFS_RAW, 2'h0);
      chk(rdat, r0 + 32'(10 * g));
      chk(speed_out | lead_on[31:0] | lead_off[63:32], 32'h0);
      @(posedge aclk) count_gate <= 1'b0;
    end
  endtask
  // 2 counts a ms over range 100: 20 rev/s, so 1200 at factor 60
  task automatic t_speed();
    wr(CPFE_OFS_CTRL, 32'h102, 2'h0);
    wr(CPFE_OFS_RANGE, 32'h64, 2'h0);
    wr(CPFE_OFS_SFACT, 32'h2710, 2'h0);
    wr(CPFE_OFS_DLY, 32'h5, 2'h0);
    @(posedge aclk) count_gate <= 1'b1;
    fork
      enc.move(4500, 1'b1, 10);
    join_none
    wq(1'b1, 32'h4B0, 45000);
    chk(lead_on[31:0], 32'hA);
    chk(lead_on[63:32], 32'hA);
    chk(lead_off[31:0], 32'hA);
    wr(CPFE_OFS_CTRL, 32'h302, 2'h0);
    wr(CPFE_OFS_DLY, 32'h30005, 2'h0);
    @(negedge aclk);
    chk(lead_off[63:32], 32'h6);
  endtask
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, count_gate, count_clear, s_axi_wstrb} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    n_fail = 0;
    compares = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bus();
    t_inc();
    t_abs();
    t_speed();
    t_timer();
    end_sim();
  end
endmodule
